/* hdl/packer_pkg.sv */
// Shared constants and types for the audio sample packer
package packer_pkg;
	// Register byte offsets
	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] MAP0_OFS = 12'h004;
	localparam logic [11:0] MAP1_OFS = 12'h008;
	localparam logic [11:0] STAT_OFS = 12'h00C;
	// Control fields and reset values
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_RES_LSB = 1;
	localparam logic CTRL_EN_RST = 1'h0;
	localparam logic [1:0] CTRL_RES_RST = 2'h1;
	localparam logic [4:0] MAP_RST = 5'h00;
	// Status fields
	localparam int STAT_PHASE_LSB = 0;
	localparam int STAT_MISS_BIT = 4;
	localparam int STAT_EN_BIT = 8;
	// Output resolution codes and widths
	localparam logic [1:0] RES_16 = 2'h0;
	localparam logic [1:0] RES_24 = 2'h1;
	localparam logic [1:0] RES_32 = 2'h2;
	localparam logic [5:0] WID_16 = 6'h10;
	localparam logic [5:0] WID_24 = 6'h18;
	localparam logic [5:0] WID_32 = 6'h20;
	// Routing source codes
	localparam logic [4:0] SRC_RAW_LAST = 5'h05;
	localparam logic [4:0] SRC_PACKED_ALL = 5'h10;
	localparam logic [4:0] SRC_PACKED_PIPE = 5'h11;
	localparam logic [4:0] SRC_PACKED_MIC = 5'h12;
	localparam logic [4:0] SRC_PACKED_REF = 5'h13;
	// Source sample indices
	localparam logic [2:0] IDX_MIC0 = 3'h0;
	localparam logic [2:0] IDX_REF_L = 3'h2;
	localparam logic [2:0] IDX_PIPE0 = 3'h4;
	localparam int NUM_SRC = 6;
	// Markers
	localparam logic MARK_ALL_MIC = 1'h0;
	localparam logic MARK_ALL_PIPE = 1'h1;
	localparam logic [7:0] MARK_TWO_A = 8'h00;
	localparam logic [7:0] MARK_TWO_B = 8'h01;
	localparam logic [7:0] MARK_TWO_C = 8'h02;
	localparam logic [7:0] PAD_BYTE = 8'h00;
	// Rates
	localparam int SRC_RATE_HZ = 16000;
	localparam int OUT_RATE_HZ = 48000;
	localparam int SLOTS_PER_SRC = OUT_RATE_HZ / SRC_RATE_HZ;
	typedef enum logic [2:0] {SLOT_A = 3'b001, SLOT_B = 3'b010, SLOT_C = 3'b100} slot_e;
	typedef enum logic [3:0] {
		PK_OFF = 4'b0001,
		PK_ALL = 4'b0010,
		PK_TWO = 4'b0100,
		PK_RAW = 4'b1000
	} pack_e;
endpackage

/* hdl/packer_slot_mux.sv */
// Builds one output slot word from the selected source samples
`timescale 1ns/10ps
`default_nettype none
module packer_slot_mux (
	input wire packer_pkg::pack_e kind,
	input wire packer_pkg::slot_e phase,
	input wire logic [31:0] keep_mask,
	input wire logic [31:0] mark_mask,
	input wire logic mark_ref,
	input wire logic [31:0] s0,
	input wire logic [31:0] s1,
	input wire logic [31:0] s2,
	output logic [31:0] word
);
	logic [31:0] pick;
	logic mark;

	// Slot word selection by packing kind and slot phase
	always_comb begin
		pick = s2;
		mark = packer_pkg::MARK_ALL_PIPE;
		word = 32'h0000_0000;
		unique case (phase)
			packer_pkg::SLOT_A: begin
				pick = s0;
				mark = packer_pkg::MARK_ALL_MIC;
			end
			packer_pkg::SLOT_B: begin
				pick = s1;
				mark = mark_ref;
			end
			packer_pkg::SLOT_C: begin
				pick = s2;
				mark = packer_pkg::MARK_ALL_PIPE;
			end
			default: begin
				pick = 32'h0000_0000;
			end
		endcase
		unique case (kind)
			packer_pkg::PK_ALL: begin
				word = (pick & keep_mask) | (mark ? mark_mask : 32'h0000_0000);
			end
			packer_pkg::PK_TWO: begin
				unique case (phase)
					packer_pkg::SLOT_A: word = {s0[31:8], packer_pkg::MARK_TWO_A};
					packer_pkg::SLOT_B: word = {s1[31:8], packer_pkg::MARK_TWO_B};
					packer_pkg::SLOT_C: word = {s0[7:0], s1[7:0], packer_pkg::PAD_BYTE,
						packer_pkg::MARK_TWO_C};
					default: word = 32'h0000_0000;
				endcase
			end
			packer_pkg::PK_RAW: word = s0;
			packer_pkg::PK_OFF: word = 32'h0000_0000;
			default: word = 32'h0000_0000;
		endcase
	end
endmodule
`default_nettype wire

/* hdl/packer_apb_regs.sv */
// APB register slave for the packer control and status
`timescale 1ns/10ps
`default_nettype none
module packer_apb_regs (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [2:0] phase_in,
	input wire logic miss_set,
	output logic ctrl_en,
	output logic [1:0] ctrl_res,
	output logic [4:0] map0,
	output logic [4:0] map1
);
	logic miss_reg;
	logic mapped;
	logic commit;
	logic [31:0] rd_next;

	assign commit = psel & penable & pready;

	// Address decode and read mux
	always_comb begin
		mapped = 1'b1;
		rd_next = 32'h0000_0000;
		unique case ({paddr[11:2], 2'b00})
			packer_pkg::CTRL_OFS: begin
				rd_next[packer_pkg::CTRL_EN_BIT] = ctrl_en;
				rd_next[packer_pkg::CTRL_RES_LSB +: 2] = ctrl_res;
			end
			packer_pkg::MAP0_OFS: rd_next[4:0] = map0;
			packer_pkg::MAP1_OFS: rd_next[4:0] = map1;
			packer_pkg::STAT_OFS: begin
				rd_next[packer_pkg::STAT_PHASE_LSB +: 3] = phase_in;
				rd_next[packer_pkg::STAT_MISS_BIT] = miss_reg;
				rd_next[packer_pkg::STAT_EN_BIT] = ctrl_en;
			end
			default: mapped = 1'b0;
		endcase
	end

	// One wait state, then answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel & penable & ~pready) begin
			pready <= 1'b1;
			prdata <= pwrite ? 32'h0000_0000 : rd_next;
			pslverr <= ~mapped;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Writes take effect at the completing edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_en <= packer_pkg::CTRL_EN_RST;
			ctrl_res <= packer_pkg::CTRL_RES_RST;
			map0 <= packer_pkg::MAP_RST;
			map1 <= packer_pkg::MAP_RST;
		end else if (commit & pwrite) begin
			unique case ({paddr[11:2], 2'b00})
				packer_pkg::CTRL_OFS: begin
					ctrl_en <= pwdata[packer_pkg::CTRL_EN_BIT];
					ctrl_res <= pwdata[packer_pkg::CTRL_RES_LSB +: 2];
				end
				packer_pkg::MAP0_OFS: map0 <= pwdata[4:0];
				packer_pkg::MAP1_OFS: map1 <= pwdata[4:0];
				default: ;
			endcase
		end
	end

	// Sticky miss flag, set wins over write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			miss_reg <= 1'b0;
		end else if (miss_set) begin
			miss_reg <= 1'b1;
		end else if (commit & pwrite & ({paddr[11:2], 2'b00} == packer_pkg::STAT_OFS)
			& pwdata[packer_pkg::STAT_MISS_BIT]) begin
			miss_reg <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* hdl/audio_sample_packer.sv */
// Packs 16 kHz audio sources into 48 kHz output slot triples
// How it works
// - Each 16 kHz source period becomes three 48 kHz output slots.
// - All-signals mode interleaves mic, ref, pipeline output per channel.
// - Packed width follows output resolution; integrated build forces 32 bits.
// - First slot holds top width-1 mic bits, marker bit 0.
// - Second slot holds ref, third pipeline output, top width-1 bits.
// - All-signals packing works at 16, 24 and 32 bit widths.
// - All-signals packing drops each sample's lowest kept bit for the marker.
// - Source code 16 on both channels resolves channel indices automatically.
// - Pipeline, mic and ref two-signal modes share one packing function.
// - Two-signal first slot: top 24 bits of sample 0, marker 0x00.
// - Two-signal second slot: top 24 bits of sample 1, marker 0x01.
// - Third slot: low bytes of samples 0 and 1, zero, marker 0x02.
`timescale 1ns/10ps
`default_nettype none
module audio_sample_packer #(
	parameter bit INTEGRATED = 1'b0,
	parameter bit MARK_REF = 1'b0
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic src_valid,
	input wire logic [31:0] mic0,
	input wire logic [31:0] mic1,
	input wire logic [31:0] ref_l,
	input wire logic [31:0] ref_r,
	input wire logic [31:0] pipe0,
	input wire logic [31:0] pipe1,
	input wire logic out_strobe,
	output logic [31:0] out_ch0,
	output logic [31:0] out_ch1,
	output logic out_valid,
	output logic out_first
);
	logic ctrl_en;
	logic [1:0] ctrl_res;
	logic [4:0] map0_code;
	logic [4:0] map1_code;
	logic [4:0] map_code [2];
	logic [31:0] src_in [packer_pkg::NUM_SRC];
	logic [31:0] hold_reg [packer_pkg::NUM_SRC];
	logic [31:0] work_reg [packer_pkg::NUM_SRC];
	logic [31:0] cur_s [packer_pkg::NUM_SRC];
	logic pending_reg;
	logic consume;
	logic miss_pulse;
	packer_pkg::slot_e phase_reg;
	packer_pkg::slot_e phase_next;
	packer_pkg::pack_e kind [2];
	logic [31:0] sel0 [2];
	logic [31:0] sel1 [2];
	logic [31:0] sel2 [2];
	logic [31:0] packed_word [2];
	logic [5:0] bits_w;
	logic [31:0] keep_mask;
	logic [31:0] mark_mask;

	// Routing code to packing kind
	function automatic packer_pkg::pack_e pack_kind(input logic [4:0] code);
		if (code == packer_pkg::SRC_PACKED_ALL) begin
			return packer_pkg::PK_ALL;
		end else if (code == packer_pkg::SRC_PACKED_PIPE || code == packer_pkg::SRC_PACKED_MIC
			|| code == packer_pkg::SRC_PACKED_REF) begin
			return packer_pkg::PK_TWO;
		end else if (code <= packer_pkg::SRC_RAW_LAST) begin
			return packer_pkg::PK_RAW;
		end
		return packer_pkg::PK_OFF;
	endfunction

	// Routing code and channel to three source indices
	function automatic logic [8:0] src_pick(input logic [4:0] code, input logic ch);
		logic [2:0] off;
		off = {2'b00, ch};
		unique case (code)
			packer_pkg::SRC_PACKED_ALL: return {packer_pkg::IDX_MIC0 + off,
				packer_pkg::IDX_REF_L + off, packer_pkg::IDX_PIPE0 + off};
			packer_pkg::SRC_PACKED_PIPE: return {packer_pkg::IDX_PIPE0,
				packer_pkg::IDX_PIPE0 + 3'h1, packer_pkg::IDX_PIPE0};
			packer_pkg::SRC_PACKED_MIC: return {packer_pkg::IDX_MIC0,
				packer_pkg::IDX_MIC0 + 3'h1, packer_pkg::IDX_MIC0};
			packer_pkg::SRC_PACKED_REF: return {packer_pkg::IDX_REF_L,
				packer_pkg::IDX_REF_L + 3'h1, packer_pkg::IDX_REF_L};
			default: return (code <= packer_pkg::SRC_RAW_LAST) ? {3{code[2:0]}} : 9'h000;
		endcase
	endfunction

	packer_apb_regs u_regs (
		.pclk(pclk),
		.presetn(presetn),
		.paddr(paddr),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.phase_in(phase_reg),
		.miss_set(miss_pulse),
		.ctrl_en(ctrl_en),
		.ctrl_res(ctrl_res),
		.map0(map0_code),
		.map1(map1_code)
	);

	// Source bundle in unpacked order
	assign src_in[0] = mic0;
	assign src_in[1] = mic1;
	assign src_in[2] = ref_l;
	assign src_in[3] = ref_r;
	assign src_in[4] = pipe0;
	assign src_in[5] = pipe1;
	assign map_code[0] = map0_code;
	assign map_code[1] = map1_code;
	always_comb begin
		if (INTEGRATED) begin
			bits_w = packer_pkg::WID_32;
		end else begin
			unique case (ctrl_res)
				packer_pkg::RES_16: bits_w = packer_pkg::WID_16;
				packer_pkg::RES_24: bits_w = packer_pkg::WID_24;
				default: bits_w = packer_pkg::WID_32;
			endcase
		end
	end

	assign keep_mask = 32'hFFFF_FFFF << (6'h21 - bits_w);
	assign mark_mask = 32'h0000_0001 << (6'h20 - bits_w);
	// Triple starts only at the first slot
	assign consume = out_strobe & ctrl_en & (phase_reg == packer_pkg::SLOT_A);
	assign miss_pulse = src_valid & pending_reg & ~consume;
	// Latest source samples
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < packer_pkg::NUM_SRC; i++) begin
				hold_reg[i] <= 32'h0000_0000;
			end
		end else if (src_valid) begin
			for (int i = 0; i < packer_pkg::NUM_SRC; i++) begin
				hold_reg[i] <= src_in[i];
			end
		end
	end
	// Pending flag, new sample wins over consume
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pending_reg <= 1'b0;
		end else if (!ctrl_en) begin
			pending_reg <= 1'b0;
		end else if (src_valid) begin
			pending_reg <= 1'b1;
		end else if (consume) begin
			pending_reg <= 1'b0;
		end
	end
	// Samples used for the current triple
	always_comb begin
		for (int i = 0; i < packer_pkg::NUM_SRC; i++) begin
			cur_s[i] = (consume & pending_reg) ? hold_reg[i] : work_reg[i];
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < packer_pkg::NUM_SRC; i++) begin
				work_reg[i] <= 32'h0000_0000;
			end
		end else if (consume) begin
			for (int i = 0; i < packer_pkg::NUM_SRC; i++) begin
				work_reg[i] <= cur_s[i];
			end
		end
	end
	always_comb begin
		unique case (phase_reg)
			packer_pkg::SLOT_A: phase_next = packer_pkg::SLOT_B;
			packer_pkg::SLOT_B: phase_next = packer_pkg::SLOT_C;
			packer_pkg::SLOT_C: phase_next = packer_pkg::SLOT_A;
			default: phase_next = packer_pkg::SLOT_A;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_reg <= packer_pkg::SLOT_A;
		end else if (!ctrl_en) begin
			phase_reg <= packer_pkg::SLOT_A;
		end else if (out_strobe) begin
			phase_reg <= phase_next;
		end
	end
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			logic [8:0] idx;
			idx = src_pick(map_code[c], c[0]);
			kind[c] = pack_kind(map_code[c]);
			sel0[c] = cur_s[idx[8:6]];
			sel1[c] = cur_s[idx[5:3]];
			sel2[c] = cur_s[idx[2:0]];
		end
	end
	for (genvar c = 0; c < 2; c++) begin : g_chan
		packer_slot_mux u_mux (
			.kind(kind[c]),
			.phase(phase_reg),
			.keep_mask(keep_mask),
			.mark_mask(mark_mask),
			.mark_ref(MARK_REF),
			.s0(sel0[c]),
			.s1(sel1[c]),
			.s2(sel2[c]),
			.word(packed_word[c])
		);
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_ch0 <= 32'h0000_0000;
			out_ch1 <= 32'h0000_0000;
			out_valid <= 1'b0;
			out_first <= 1'b0;
		end else begin
			out_valid <= out_strobe & ctrl_en;
			out_first <= consume;
			if (!ctrl_en) begin
				out_ch0 <= 32'h0000_0000;
				out_ch1 <= 32'h0000_0000;
			end else if (out_strobe) begin
				out_ch0 <= packed_word[0];
				out_ch1 <= packed_word[1];
			end
		end
	end
	// Slots seen since the last triple start
	logic [1:0] slot_cnt;
	logic seen_first;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slot_cnt <= 2'h0;
			seen_first <= 1'b0;
		end else if (out_valid) begin
			slot_cnt <= out_first ? 2'h0 : slot_cnt + 2'h1;
			seen_first <= seen_first | out_first;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_start(int k);
		consume && kind[0] == k;
	endsequence
	sequence s_slot(packer_pkg::slot_e p, int k);
		out_strobe && ctrl_en && phase_reg == p && kind[0] == k;
	endsequence
	property p_three_slots;
		out_valid && out_first && seen_first |-> slot_cnt == 2'h2;
	endproperty
	a_three_slots: assert property (p_three_slots) else $error("triple not three slots");
	property p_gapless;
		out_strobe && ctrl_en |=> out_valid && (out_first == $past(phase_reg == packer_pkg::SLOT_A));
	endproperty
	a_gapless: assert property (p_gapless) else $error("slot missing or misaligned");
	property p_int_width;
		bits_w == (INTEGRATED ? packer_pkg::WID_32 : (ctrl_res == packer_pkg::RES_16) ?
			packer_pkg::WID_16 : (ctrl_res == packer_pkg::RES_24) ? packer_pkg::WID_24 :
			packer_pkg::WID_32);
	endproperty
	a_int_width: assert property (p_int_width) else $error("packed width wrong");
	property p_all_mic;
		s_start(packer_pkg::PK_ALL) |=> (out_ch0 & keep_mask) == ($past(sel0[0]) & keep_mask)
			&& (out_ch0 & mark_mask) == 32'h0000_0000;
	endproperty
	a_all_mic: assert property (p_all_mic) else $error("mic slot wrong");
	property p_all_ref;
		s_slot(packer_pkg::SLOT_B, packer_pkg::PK_ALL) |=>
			((out_ch0 & mark_mask) != 32'h0000_0000) == MARK_REF
			&& (out_ch0 & keep_mask) == ($past(sel1[0]) & keep_mask);
	endproperty
	a_all_ref: assert property (p_all_ref) else $error("ref slot wrong");
	property p_all_pipe;
		s_slot(packer_pkg::SLOT_C, packer_pkg::PK_ALL) |=> (out_ch0 & mark_mask) == mark_mask
			&& (out_ch0 & keep_mask) == ($past(sel2[0]) & keep_mask);
	endproperty
	a_all_pipe: assert property (p_all_pipe) else $error("pipe slot wrong");
	property p_all_low_zero;
		s_slot(packer_pkg::SLOT_A, packer_pkg::PK_ALL) |=> (out_ch0 & ~(keep_mask | mark_mask))
			== 32'h0000_0000;
	endproperty
	a_all_low_zero: assert property (p_all_low_zero) else $error("bits below width set");
	property p_ch1_mic1;
		consume && map1_code == packer_pkg::SRC_PACKED_ALL |=>
			(out_ch1 & keep_mask) == ($past(cur_s[1]) & keep_mask);
	endproperty
	a_ch1_mic1: assert property (p_ch1_mic1) else $error("channel 1 index wrong");
	property p_two_a;
		s_start(packer_pkg::PK_TWO) |=> out_ch0 == {$past(sel0[0][31:8]), packer_pkg::MARK_TWO_A};
	endproperty
	a_two_a: assert property (p_two_a) else $error("two-signal slot A wrong");
	property p_two_b;
		s_slot(packer_pkg::SLOT_B, packer_pkg::PK_TWO) |=>
			out_ch0 == {$past(sel1[0][31:8]), packer_pkg::MARK_TWO_B};
	endproperty
	a_two_b: assert property (p_two_b) else $error("two-signal slot B wrong");
	property p_two_c;
		s_slot(packer_pkg::SLOT_C, packer_pkg::PK_TWO) |=> out_ch0 == {$past(sel0[0][7:0]),
			$past(sel1[0][7:0]), packer_pkg::PAD_BYTE, packer_pkg::MARK_TWO_C};
	endproperty
	a_two_c: assert property (p_two_c) else $error("two-signal slot C wrong");
	property p_mic_pair;
		consume && map0_code == packer_pkg::SRC_PACKED_MIC |=>
			out_ch0[31:8] == $past(cur_s[0][31:8]);
	endproperty
	a_mic_pair: assert property (p_mic_pair) else $error("mic pair wrong");
endmodule
`default_nettype wire

/* bench/host_capture_model.sv */
// Host capture model: paces output slots and records delivered words
`timescale 1ns/10ps
`default_nettype none
module host_capture_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic req,
	input wire logic [3:0] gap,
	input wire logic [31:0] out_ch0,
	input wire logic [31:0] out_ch1,
	input wire logic out_valid,
	input wire logic out_first,
	output logic out_strobe,
	output logic done,
	output logic [31:0] cap0 [0:2],
	output logic [31:0] cap1 [0:2],
	output logic [2:0] firsts,
	output logic [2:0] n_cap
);
	logic busy;
	logic [1:0] slot;
	logic [3:0] wait_cnt;
	// Slot pacing, three strobes at a steady spacing
	// steady slot rate
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_strobe <= 1'b0;
			done <= 1'b0;
			busy <= 1'b0;
			slot <= 2'h0;
			wait_cnt <= 4'h0;
		end else begin
			out_strobe <= 1'b0;
			done <= 1'b0;
			if (req && !busy) begin
				busy <= 1'b1;
				slot <= 2'h0;
				wait_cnt <= gap;
			end else if (busy) begin
				if (wait_cnt != 4'h0) begin
					wait_cnt <= wait_cnt - 4'h1;
				end else if (slot == 2'h3) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					out_strobe <= 1'b1;
					slot <= slot + 2'h1;
					wait_cnt <= gap;
				end
			end
		end
	end
	// Words kept exactly as delivered
	// unscaled capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			n_cap <= 3'h0;
			firsts <= 3'h0;
		end else if (req) begin
			n_cap <= 3'h0;
			firsts <= 3'h0;
		end else if (out_valid) begin
			if (n_cap < 3'h3) begin
				cap0[n_cap[1:0]] <= out_ch0;
				cap1[n_cap[1:0]] <= out_ch1;
				firsts[3'h2 - n_cap] <= out_first;
			end
			n_cap <= n_cap + 3'h1;
		end
	end
endmodule
`default_nettype wire

/* bench/audio_sample_packer_bench.sv */
// Self-checking bench for the audio sample packer
`timescale 1ns/10ps
`default_nettype none
module audio_sample_packer_bench;
	typedef struct {logic [4:0] code; logic [1:0] res; logic [5:0] w;} row_s;
	localparam bit mark_b = 1'b0;
	logic pclk, presetn, psel, penable, pwrite, src_valid, req, pready, pslverr, e;
	logic out_strobe, out_valid, out_first, done;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, out_ch0, out_ch1, q;
	logic [31:0] mic0, mic1, ref_l, ref_r, pipe0, pipe1;
	logic [31:0] cap0 [0:2];
	logic [31:0] cap1 [0:2];
	logic [31:0] src [0:5];
	logic [2:0] firsts, n_cap;
	logic [3:0] gap;
	int miscompares, n_checks;
	row_s rows [0:8];
	audio_sample_packer #(.INTEGRATED(1'b0), .MARK_REF(mark_b)) uut (.pclk(pclk),
		.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.src_valid(src_valid), .mic0(mic0), .mic1(mic1), .ref_l(ref_l), .ref_r(ref_r),
		.pipe0(pipe0), .pipe1(pipe1), .out_strobe(out_strobe), .out_ch0(out_ch0),
		.out_ch1(out_ch1), .out_valid(out_valid), .out_first(out_first));
	host_capture_model host (.pclk(pclk), .presetn(presetn), .req(req), .gap(gap),
		.out_ch0(out_ch0), .out_ch1(out_ch1), .out_valid(out_valid), .out_first(out_first),
		.out_strobe(out_strobe), .done(done), .cap0(cap0), .cap1(cap1), .firsts(firsts),
		.n_cap(n_cap));
	// Clock source
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_checks++;
		if (seen !== want) begin
			miscompares++;
			$display("Error %0t: got %h want %h", $time, seen, want);
		end
	endtask
	task automatic conclude();
		if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// One APB transfer, entered just after a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) miscompares++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] want, input logic err);
		apb(1'b0, a, 32'h0000_0000);
		check(q, want);
		check({31'h0, e}, {31'h0, err});
	endtask
	// New sample set, then one slot triple paced by the host model
	task automatic run_triple(input logic [3:0] g);
		int n;
		for (int k = 0; k < 6; k++) src[k] = {src[k][30:0], src[k][31]};
		{mic0, mic1, ref_l, ref_r, pipe0, pipe1} <= {src[0], src[1], src[2], src[3], src[4], src[5]};
		src_valid <= 1'b1;
		gap <= g;
		@(posedge pclk);
		src_valid <= 1'b0;
		req <= 1'b1;
		@(posedge pclk);
		req <= 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 200) begin
			@(negedge pclk);
			n++;
		end
		if (n >= 200) miscompares++;
		@(posedge pclk);
	endtask
	function automatic logic [31:0] expect_word(row_s r, int slot, int ch);
		logic [31:0] t, s0, s1;
		int b;
		t = 32'h0000_0000;
		if (r.code == packer_pkg::SRC_PACKED_ALL) begin
			t = src[slot * 2 + ch] & (32'hffff_ffff << (33 - int'(r.w)));
			t[32 - int'(r.w)] = (slot == 0) ? packer_pkg::MARK_ALL_MIC :
				(slot == 1) ? mark_b : packer_pkg::MARK_ALL_PIPE;
		end else if (r.code >= packer_pkg::SRC_PACKED_PIPE && r.code <= packer_pkg::SRC_PACKED_REF) begin
			b = (r.code == packer_pkg::SRC_PACKED_PIPE) ? 4 : (r.code == packer_pkg::SRC_PACKED_MIC) ? 0 : 2;
			s0 = src[b];
			s1 = src[b + 1];
			if (slot == 0) t = {s0[31:8], packer_pkg::MARK_TWO_A};
			else if (slot == 1) t = {s1[31:8], packer_pkg::MARK_TWO_B};
			else t = {s0[7:0], s1[7:0], packer_pkg::PAD_BYTE, packer_pkg::MARK_TWO_C};
		end else if (r.code <= packer_pkg::SRC_RAW_LAST) begin
			t = src[r.code];
		end
		return t;
	endfunction
	// Watchdog
	initial begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		conclude();
	end
	// Main sequence
	initial begin
		{presetn, psel, penable, pwrite, src_valid, req} = 6'h00;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		gap = 4'h1;
		src = '{32'h8123_4567, 32'h7edc_ba98, 32'hc0de_1357, 32'h3579_bdf1, 32'ha5a5_5a5b, 32'h1e2d_3c4a};
		{mic0, mic1, ref_l, ref_r, pipe0, pipe1} = {src[0], src[1], src[2], src[3], src[4], src[5]};
		rows = '{'{5'h10, 2'h0, 6'h10}, '{5'h10, 2'h1, 6'h18}, '{5'h10, 2'h2, 6'h20},
			'{5'h10, 2'h3, 6'h20}, '{5'h11, 2'h2, 6'h20}, '{5'h12, 2'h2, 6'h20},
			'{5'h13, 2'h2, 6'h20}, '{5'h03, 2'h2, 6'h20}, '{5'h07, 2'h1, 6'h18}};
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check(out_ch0 | out_ch1, 32'h0000_0000);
		rd(packer_pkg::CTRL_OFS, 32'h0000_0002, 1'b0);
		rd(packer_pkg::STAT_OFS, 32'h0000_0001, 1'b0);
		rd(12'h010, 32'h0000_0000, 1'b1);
		// Each packing kind, all-signals at every width, prompt and slow host pacing
		for (int i = 0; i < 9; i++) begin
			apb(1'b1, packer_pkg::CTRL_OFS, {29'h0, rows[i].res, 1'b1});
			apb(1'b1, packer_pkg::MAP0_OFS, {27'h0, rows[i].code});
			apb(1'b1, packer_pkg::MAP1_OFS, {27'h0, rows[i].code});
			run_triple((i % 2) ? 4'h1 : 4'h6);
			check({29'h0, firsts}, 32'h0000_0004);
			for (int s = 0; s < 3; s++) begin
				check(cap0[s], expect_word(rows[i], s, 0));
				check(cap1[s], expect_word(rows[i], s, 1));
			end
		end
		// Unused sample set overwritten, miss flag then cleared
		src_valid <= 1'b1;
		@(posedge pclk);
		src_valid <= 1'b0;
		@(posedge pclk);
		src_valid <= 1'b1;
		@(posedge pclk);
		src_valid <= 1'b0;
		@(posedge pclk);
		rd(packer_pkg::STAT_OFS, 32'h0000_0111, 1'b0);
		apb(1'b1, packer_pkg::STAT_OFS, 32'h0000_0010);
		rd(packer_pkg::STAT_OFS, 32'h0000_0101, 1'b0);
		// Disabled packer gives no slots
		// no output disabled
		apb(1'b1, packer_pkg::CTRL_OFS, 32'h0000_0002);
		run_triple(4'h1);
		check({29'h0, n_cap}, 32'h0000_0000);
		check(out_ch0, 32'h0000_0000);
		conclude();
	end
endmodule
`default_nettype wire
